// ===== pds_ctrl.sv
// Purpose: Loop calibration sequencing, post-divider ranges, digital loop and output routing.
// Assumes: Analog calibration engine reports done and lock per loop.
// Notes: Loop index 0 is the first loop, 1 the second, 2 the resonator loop.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pds_ctrl
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire pds_pkg::pds_apb_req_t i_apb,
  output pds_pkg::pds_apb_rsp_t o_apb,
  input wire logic i_xo_ok,
  input wire logic [2:0] i_cal_done,
  input wire logic [2:0] i_lock,
  input wire logic [1:0] i_ref_clk,
  input wire logic i_fb_clk,
  output logic [2:0] o_cal_start,
  output pds_pkg::pds_route_t o_route,
  output pds_pkg::pds_align_t o_align,
  output logic [39:0] o_steer_num,
  output logic o_steer_vld
);
  import pds_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] clampr(input logic [3:0] v, input logic [3:0] lo,
                                        input logic [3:0] hi);
    clampr = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampr

  function automatic logic src_ok(input logic [2:0] code, input pds_cal_t [2:0] cal);
    unique case (code)
      PDS_S_RES: src_ok = (cal[2] == CAL_READY);
      PDS_S_L2: src_ok = (cal[1] == CAL_READY);
      PDS_S_L1P, PDS_S_L1S: src_ok = (cal[0] == CAL_READY);
      default: src_ok = 1'b1;
    endcase
  endfunction : src_ok

  function automatic logic [2:0] bank_code(input logic [1:0] s, input logic block_res);
    bank_code = (s == 2'h3 || (s == 2'h0 && block_res)) ? PDS_S_NONE : {1'b0, s};
  endfunction : bank_code

  pds_state_t r;
  pds_state_t n;
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [31:0] wd;
  logic [1:0] ref_evt;
  logic fb_edge;
  logic pre_evt;
  logic fb_evt;
  logic div_evt;
  logic [40:0] asum;
  logic [15:0] terr;
  logic [39:0] err40;
  logic [3:0] rb;
  logic ref_valid;
  logic res_byp;

  // ==========================================================
  // Next state
  always_comb
  begin
    n = r;
    wd = i_apb.pwdata;
    setup = i_apb.psel && !i_apb.penable && !r.rsp.pready;
    wr = i_apb.psel && i_apb.penable && r.rsp.pready && i_apb.pwrite;
    hit = 1'b1;
    rd = 32'h0;
    asum = 41'h0;
    terr = 16'h0;
    err40 = 40'h0;
    rb = 4'h0;
    n.cal_start = 3'h0;
    n.align.sync = 1'b0;
    n.steer_vld = 1'b0;

    // Calibration sequencing per loop.
    for (int i = 0; i < 3; i++)
    begin
      unique case (r.cal[i])
        CAL_IDLE: n.cal[i] = CAL_IDLE;
        CAL_WAIT_XO:
        begin
          if (i_xo_ok) // RULE1
          begin
            n.cal[i] = CAL_RUN;
            n.cal_start[i] = 1'b1;
          end
        end
        CAL_RUN:
        begin
          if (i_cal_done[i])
            n.cal[i] = CAL_LOCK;
        end
        CAL_LOCK:
        begin
          if (i_lock[i])
            n.cal[i] = CAL_READY;
        end
        CAL_READY:
        begin
          if (!i_lock[i])
            n.cal[i] = CAL_LOCK;
        end
      endcase
    end

    // Digital loop: reference dividers and selected divided reference.
    ref_evt = 2'h0;
    for (int i = 0; i < 2; i++)
    begin
      if (i_ref_clk[i] && !r.ref_q[i])
      begin
        if (i == 0)
        begin
          ref_evt[0] = (r.rc0 + 16'h1 >= r.rdiv0); // RULE11
          n.rc0 = ref_evt[0] ? 16'h0 : r.rc0 + 16'h1;
        end
        else
        begin
          ref_evt[1] = (r.rc1 + 16'h1 >= r.rdiv1); // RULE11
          n.rc1 = ref_evt[1] ? 16'h0 : r.rc1 + 16'h1;
        end
      end
    end
    n.ref_q = i_ref_clk;
    div_evt = r.dref ? ref_evt[1] : ref_evt[0]; // RULE11

    // Feedback path: prescaler then fractional divider.
    fb_edge = i_fb_clk && !r.fb_q;
    n.fb_q = i_fb_clk;
    pre_evt = 1'b0;
    fb_evt = 1'b0;
    if (fb_edge)
    begin
      pre_evt = (r.pc + PDS_ONE33 >= r.pre); // RULE14
      n.pc = pre_evt ? 33'h0 : r.pc + PDS_ONE33;
    end
    if (pre_evt)
    begin
      fb_evt = (r.fc + PDS_ONE33 >= r.modu);
      n.fc = fb_evt ? 33'h0 : r.fc + PDS_ONE33;
      if (fb_evt)
      begin
        asum = {1'b0, r.acc} + {1'b0, r.num}; // RULE15
        if (asum >= {1'b0, r.den})
        begin
          n.acc = 40'(asum - {1'b0, r.den});
          n.modu = r.fint + PDS_ONE33;
        end
        else
        begin
          n.acc = asum[39:0];
          n.modu = r.fint;
        end
      end
    end

    // Phase comparator and loop filter.
    n.tnow = r.tnow + 16'h1;
    if (div_evt)
      n.tref = r.tnow;
    if (fb_evt)
    begin
      terr = r.tnow - r.tref; // RULE12
      err40 = {{24{terr[15]}}, terr};
      n.integ = r.integ + err40;
      n.steer = r.num + 40'(err40 << r.bw) + r.integ + err40; // RULE13
      n.steer_vld = 1'b1;
    end

    // Post-divider ratio ranges.
    rb = clampr(r.res_ratio, 4'h1, 4'h8);
    res_byp = (rb == 4'h1); // RULE6
    n.route.res_div = (r.res_x2 && rb >= 4'h5) ? {rb, 1'b0} : {1'b0, rb}; // RULE5
    n.route.l2_div = clampr(r.l2_ratio, 4'h2, 4'hd); // RULE8
    n.route.l1p_div = 3'(clampr({1'b0, r.l1p}, 4'h2, 4'h7)); // RULE9
    n.route.l1s_div = 3'(clampr({1'b0, r.l1s}, 4'h2, 4'h7)); // RULE10

    // Output source selection.
    ref_valid = r.ref_en && (r.ref_sel == 5'h1 || r.ref_sel == 5'h2); // RULE21
    n.route.ref_pick = ref_valid ? r.ref_sel[1:0] : 2'h0; // RULE21
    for (int i = 0; i < 2; i++)
    begin
      n.route.src[i] = (i == 0) ? r.o0sel : r.o1sel; // RULE18
      if (n.route.src[i] > PDS_S_REF || (n.route.src[i] == PDS_S_REF && !ref_valid))
        n.route.src[i] = PDS_S_NONE; // RULE21
    end
    n.route.src[2] = bank_code(r.s2, 1'b0); // RULE19
    n.route.src[3] = bank_code(r.s3, 1'b0); // RULE19
    n.route.src[14] = bank_code(r.s14, !res_byp); // RULE6
    n.route.src[15] = bank_code(r.s15, !res_byp); // RULE6
    for (int p = 0; p < 5; p++)
    begin
      n.route.src[4 + 2 * p] = r.pair_sel[p] ? PDS_S_L2 : PDS_S_RES; // RULE20
      n.route.src[5 + 2 * p] = r.pair_sel[p] ? PDS_S_L2 : PDS_S_RES; // RULE20
    end
    for (int i = 0; i < 16; i++)
      n.route.mute[i] = r.mute_en[i] && !src_ok(n.route.src[i], r.cal); // RULE2

    // Register read mux.
    unique case (i_apb.paddr)
      PDS_A_CTRL: rd = {17'h0, r.align.en, 9'h0, r.en};
      PDS_A_STAT:
      begin
        rd[PDS_F_MUTED +: 16] = r.route.mute;
        rd[PDS_F_XO] = i_xo_ok;
        for (int i = 0; i < 3; i++)
        begin
          rd[i] = (r.cal[i] == CAL_READY);
          rd[PDS_F_BUSY + i] = (r.cal[i] == CAL_RUN || r.cal[i] == CAL_WAIT_XO);
        end
      end
      PDS_A_MUTE: rd = {16'h0, r.mute_en};
      PDS_A_PDIV: rd = {13'h0, r.l1s, 1'b0, r.l1p, r.l2_ratio, 3'h0, r.res_x2, r.res_ratio};
      PDS_A_SRC01: rd = {11'h0, r.ref_sel, 7'h0, r.ref_en, 1'b0, r.o1sel, 1'b0, r.o0sel};
      PDS_A_SRCB: rd = {19'h0, r.pair_sel, r.s15, r.s14, r.s3, r.s2};
      PDS_A_RDIV0: rd = {16'h0, r.rdiv0};
      PDS_A_RDIV1: rd = {16'h0, r.rdiv1};
      PDS_A_PRE_L: rd = r.pre[31:0];
      PDS_A_PRE_H: rd = {31'h0, r.pre[32]};
      PDS_A_INT_L: rd = r.fint[31:0];
      PDS_A_INT_H: rd = {31'h0, r.fint[32]};
      PDS_A_NUM_L: rd = r.num[31:0];
      PDS_A_NUM_H: rd = {24'h0, r.num[39:32]};
      PDS_A_DEN_L: rd = r.den[31:0];
      PDS_A_DEN_H: rd = {24'h0, r.den[39:32]};
      PDS_A_LF: rd = {23'h0, r.dref, 4'h0, r.bw};
      PDS_A_ZD: rd = {16'h0, r.align.offset};
      PDS_A_STEER: rd = r.steer[31:0];
      default: hit = 1'b0;
    endcase

    // Register writes.
    if (wr && hit)
    begin
      unique case (i_apb.paddr)
        PDS_A_CTRL:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (wd[i] && !r.en[i])
              n.cal[i] = CAL_WAIT_XO; // RULE3 RULE4
            else if (!wd[i])
              n.cal[i] = CAL_IDLE;
          end
          n.en = wd[2:0];
          n.align.sync = wd[PDS_F_SYNC]; // RULE16
          n.align.en = wd[PDS_F_ZDEN +: 3]; // RULE17
        end
        PDS_A_MUTE: n.mute_en = wd[15:0];
        PDS_A_PDIV:
        begin
          n.res_ratio = wd[3:0];
          n.res_x2 = wd[PDS_F_X2];
          n.l2_ratio = wd[PDS_F_L2 +: 4];
          n.l1p = wd[PDS_F_L1P +: 3];
          n.l1s = wd[PDS_F_L1S +: 3];
        end
        PDS_A_SRC01:
        begin
          n.o0sel = wd[2:0];
          n.o1sel = wd[PDS_F_O1 +: 3];
          n.ref_en = wd[PDS_F_REFEN];
          n.ref_sel = wd[PDS_F_REFSEL +: 5];
        end
        PDS_A_SRCB:
        begin
          n.s2 = wd[1:0];
          n.s3 = wd[PDS_F_S3 +: 2];
          n.s14 = wd[PDS_F_S14 +: 2];
          n.s15 = wd[PDS_F_S15 +: 2];
          n.pair_sel = wd[PDS_F_PAIR +: 5];
        end
        PDS_A_RDIV0: n.rdiv0 = (wd[15:0] == 16'h0) ? PDS_RDIV_RST : wd[15:0];
        PDS_A_RDIV1: n.rdiv1 = (wd[15:0] == 16'h0) ? PDS_RDIV_RST : wd[15:0];
        PDS_A_PRE_L: n.pre[31:0] = wd;
        PDS_A_PRE_H: n.pre[32] = wd[0];
        PDS_A_INT_L: n.fint[31:0] = wd;
        PDS_A_INT_H: n.fint[32] = wd[0];
        PDS_A_NUM_L: n.num[31:0] = wd;
        PDS_A_NUM_H: n.num[39:32] = wd[7:0];
        PDS_A_DEN_L: n.den[31:0] = wd;
        PDS_A_DEN_H: n.den[39:32] = wd[7:0];
        PDS_A_LF:
        begin
          n.bw = wd[3:0];
          n.dref = wd[PDS_F_DREF];
        end
        PDS_A_ZD: n.align.offset = wd[15:0]; // RULE17
        default: hit = 1'b1;
      endcase
      if (n.pre == 33'h0)
        n.pre = PDS_ONE33; // RULE14
      if (n.den == 40'h0)
        n.den = PDS_DEN_RST;
    end

    // Bus answer: ready one cycle after setup.
    n.rsp.pready = setup;
    if (setup)
    begin
      n.rsp.prdata = i_apb.pwrite ? 32'h0 : rd;
      n.rsp.pslverr = !hit;
    end
    else
    begin
      n.rsp.prdata = 32'h0;
      n.rsp.pslverr = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r <= '0;
      r.cal <= '{CAL_WAIT_XO, CAL_WAIT_XO, CAL_WAIT_XO};
      r.route.res_div <= {1'b0, PDS_RES_RST};
      r.en <= PDS_EN_RST;
      r.mute_en <= PDS_MUTE_RST;
      r.route.mute <= PDS_MUTE_RST;
      r.res_ratio <= PDS_RES_RST;
      r.l2_ratio <= PDS_L2_RST;
      r.l1p <= PDS_L1_RST;
      r.l1s <= PDS_L1_RST;
      r.rdiv0 <= PDS_RDIV_RST;
      r.rdiv1 <= PDS_RDIV_RST;
      r.pre <= PDS_ONE33;
      r.fint <= PDS_ONE33;
      r.modu <= PDS_ONE33;
      r.den <= PDS_DEN_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_apb = r.rsp;
  assign o_cal_start = r.cal_start;
  assign o_route = r.route;
  assign o_align = r.align;
  assign o_steer_num = r.steer;
  assign o_steer_vld = r.steer_vld;
endmodule : pds_ctrl

// ===== pds_pkg.sv
// Purpose: Constants and types for the loop divider and output source control block.
// Assumes: APB slave with 32-bit data; all clock-like inputs are synchronous to i_clk.
// Notes: Register offsets are byte addresses.
// How it works
// RULE1: After reset each loop calibrates once the crystal input is detected.
// RULE2: Outputs with muting enabled stay muted until their loop is calibrated and locked.
// RULE3: Rising edge of one loop enable bit recalibrates only that loop.
// RULE4: Host cycles the loop enable after changing a running feedback divider.
// RULE5: Resonator post-divider gives 2 to 8, or 10 to 16 with extra halving.
// RULE6: Resonator post-divider of 1 bypasses it and feeds every output bank.
// RULE7: Host should feed the last bank from another loop when dividing.
// RULE8: Second loop post-divider ratios 2 to 13, selectable by every output.
// RULE9: First loop primary post-divider, 2 to 7, reaches outputs 0-3, 14, 15.
// RULE10: First loop secondary post-divider, 2 to 7, reaches outputs 0 and 1.
// RULE11: Each reference has a 16-bit divider; selected one clocks the comparator.
// RULE12: Phase comparator turns reference-to-feedback time into an error word.
// RULE13: Loop filter with programmable bandwidth steers the fractional numerator.
// RULE14: Feedback prescaler is 33 bits, values 1 to two to the 33 minus one.
// RULE15: Feedback divider ratio is 33-bit integer plus 40-bit numerator over denominator.
// RULE16: A sync command phase-aligns the output dividers.
// RULE17: Outputs 0, 4 and 10 offer zero-delay alignment with a programmable offset.
// RULE18: Outputs 0 and 1 each select among six sources.
// RULE19: Outputs 2, 3, 14, 15 each select among three sources.
// RULE20: Outputs 4 to 13 share one two-way selector per adjacent pair.
// RULE21: Reference reaches outputs 0/1 only when enabled; 5-bit field picks it.
// RULE22: Host should give grouped outputs the same source selection.
package pds_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] PDS_A_CTRL = 8'h00;
  localparam logic [7:0] PDS_A_STAT = 8'h04;
  localparam logic [7:0] PDS_A_MUTE = 8'h08;
  localparam logic [7:0] PDS_A_PDIV = 8'h0c;
  localparam logic [7:0] PDS_A_SRC01 = 8'h10;
  localparam logic [7:0] PDS_A_SRCB = 8'h14;
  localparam logic [7:0] PDS_A_RDIV0 = 8'h18;
  localparam logic [7:0] PDS_A_RDIV1 = 8'h1c;
  localparam logic [7:0] PDS_A_PRE_L = 8'h20;
  localparam logic [7:0] PDS_A_PRE_H = 8'h24;
  localparam logic [7:0] PDS_A_INT_L = 8'h28;
  localparam logic [7:0] PDS_A_INT_H = 8'h2c;
  localparam logic [7:0] PDS_A_NUM_L = 8'h30;
  localparam logic [7:0] PDS_A_NUM_H = 8'h34;
  localparam logic [7:0] PDS_A_DEN_L = 8'h38;
  localparam logic [7:0] PDS_A_DEN_H = 8'h3c;
  localparam logic [7:0] PDS_A_LF = 8'h40;
  localparam logic [7:0] PDS_A_ZD = 8'h44;
  localparam logic [7:0] PDS_A_STEER = 8'h48;
  // ==========================================================
  // Field positions
  localparam int PDS_F_SYNC = 8;
  localparam int PDS_F_ZDEN = 12;
  localparam int PDS_F_X2 = 4;
  localparam int PDS_F_L2 = 8;
  localparam int PDS_F_L1P = 12;
  localparam int PDS_F_L1S = 16;
  localparam int PDS_F_O1 = 4;
  localparam int PDS_F_REFEN = 8;
  localparam int PDS_F_REFSEL = 16;
  localparam int PDS_F_S3 = 2;
  localparam int PDS_F_S14 = 4;
  localparam int PDS_F_S15 = 6;
  localparam int PDS_F_PAIR = 8;
  localparam int PDS_F_DREF = 8;
  localparam int PDS_F_BUSY = 3;
  localparam int PDS_F_XO = 8;
  localparam int PDS_F_MUTED = 16;
  // ==========================================================
  // Reset values and source codes
  localparam logic [2:0] PDS_EN_RST = 3'h7;
  localparam logic [15:0] PDS_MUTE_RST = 16'hffff;
  localparam logic [3:0] PDS_RES_RST = 4'h1;
  localparam logic [3:0] PDS_L2_RST = 4'h2;
  localparam logic [2:0] PDS_L1_RST = 3'h2;
  localparam logic [15:0] PDS_RDIV_RST = 16'h0001;
  localparam logic [32:0] PDS_ONE33 = 33'h1;
  localparam logic [39:0] PDS_DEN_RST = 40'h1;
  localparam logic [2:0] PDS_S_RES = 3'h0;
  localparam logic [2:0] PDS_S_L2 = 3'h1;
  localparam logic [2:0] PDS_S_L1P = 3'h2;
  localparam logic [2:0] PDS_S_L1S = 3'h3;
  localparam logic [2:0] PDS_S_XO = 3'h4;
  localparam logic [2:0] PDS_S_REF = 3'h5;
  localparam logic [2:0] PDS_S_NONE = 3'h7;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {CAL_IDLE, CAL_WAIT_XO, CAL_RUN, CAL_LOCK, CAL_READY} pds_cal_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pds_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pds_apb_rsp_t;
  typedef struct packed {
    logic [15:0][2:0] src;
    logic [15:0] mute;
    logic [4:0] res_div;
    logic [3:0] l2_div;
    logic [2:0] l1p_div;
    logic [2:0] l1s_div;
    logic [1:0] ref_pick;
  } pds_route_t;
  typedef struct packed {
    logic sync;
    logic [2:0] en;
    logic [15:0] offset;
  } pds_align_t;
  typedef struct packed {
    pds_apb_rsp_t rsp;
    pds_route_t route;
    pds_align_t align;
    pds_cal_t [2:0] cal;
    logic [2:0] cal_start;
    logic [2:0] en;
    logic [15:0] mute_en;
    logic [3:0] res_ratio;
    logic res_x2;
    logic [3:0] l2_ratio;
    logic [2:0] l1p;
    logic [2:0] l1s;
    logic [2:0] o0sel;
    logic [2:0] o1sel;
    logic ref_en;
    logic [4:0] ref_sel;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] s14;
    logic [1:0] s15;
    logic [4:0] pair_sel;
    logic [15:0] rdiv0;
    logic [15:0] rdiv1;
    logic dref;
    logic [32:0] pre;
    logic [32:0] fint;
    logic [39:0] num;
    logic [39:0] den;
    logic [3:0] bw;
    logic [15:0] rc0;
    logic [15:0] rc1;
    logic [1:0] ref_q;
    logic fb_q;
    logic [32:0] pc;
    logic [32:0] fc;
    logic [32:0] modu;
    logic [39:0] acc;
    logic [15:0] tnow;
    logic [15:0] tref;
    logic [39:0] integ;
    logic [39:0] steer;
    logic steer_vld;
  } pds_state_t;
endpackage : pds_pkg

// ===== pds_ctrl_asserts.sv
// Purpose: Port assertions for pds_ctrl.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: Bound to every pds_ctrl instance at the foot of this file.
`timescale 1ns/1ps
module pds_ctrl_asserts
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire pds_pkg::pds_apb_req_t i_apb,
  input wire pds_pkg::pds_apb_rsp_t o_apb,
  input wire logic i_xo_ok,
  input wire logic [2:0] i_cal_done,
  input wire logic [2:0] i_lock,
  input wire logic [1:0] i_ref_clk,
  input wire logic i_fb_clk,
  input wire logic [2:0] o_cal_start,
  input wire pds_pkg::pds_route_t o_route,
  input wire pds_pkg::pds_align_t o_align,
  input wire logic [39:0] o_steer_num,
  input wire logic o_steer_vld
);
  import pds_pkg::*;
  logic b9;
  logic b10;
  logic b20;
  logic wsync;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Helpers
  assign wsync = i_apb.psel && i_apb.penable && i_apb.pwrite
    && i_apb.paddr == PDS_A_CTRL && i_apb.pwdata[PDS_F_SYNC];
  always_comb
  begin
    b9 = 1'b0;
    b10 = 1'b0;
    b20 = 1'b0;
    for (int k = 2; k < 16; k++)
    begin
      b9 |= (k > 3) && (k < 14) && (o_route.src[k] == PDS_S_L1P);
      b10 |= o_route.src[k] == PDS_S_L1S;
    end
    for (int p = 0; p < 5; p++)
    begin
      b20 |= (o_route.src[4 + 2 * p] != o_route.src[5 + 2 * p])
        || (o_route.src[4 + 2 * p] > PDS_S_L2);
    end
  end
  // ==========================================================
  // Properties
  property p_xo;
    |o_cal_start |-> $past(i_xo_ok);
  endproperty
  a_xo: assert property (p_xo) else $error("calibration without crystal");
  property p_unmute;
    $fell(o_route.mute[2]) && o_route.src[2] == PDS_S_RES |-> $past(i_lock[2]);
  endproperty
  a_unmute: assert property (p_unmute) else $error("unmuted before lock");
  property p_res;
    o_route.res_div inside {[1:8], 10, 12, 14, 16};
  endproperty
  a_res: assert property (p_res) else $error("bad resonator ratio");
  property p_bypass;
    o_route.src[14] == PDS_S_RES || o_route.src[15] == PDS_S_RES |-> o_route.res_div == 5'h01;
  endproperty
  a_bypass: assert property (p_bypass) else $error("last bank on divided source");
  property p_l2;
    $past(i_reset_n) |-> o_route.l2_div inside {[2:13]};
  endproperty
  a_l2: assert property (p_l2) else $error("bad second loop ratio");
  property p_l1p;
    $past(i_reset_n) |-> o_route.l1p_div inside {[2:7]} && !b9;
  endproperty
  a_l1p: assert property (p_l1p) else $error("bad primary divider use");
  property p_l1s;
    $past(i_reset_n) |-> o_route.l1s_div inside {[2:7]} && !b10;
  endproperty
  a_l1s: assert property (p_l1s) else $error("bad secondary divider use");
  property p_steer;
    $changed(o_steer_num) |-> o_steer_vld;
  endproperty
  a_steer: assert property (p_steer) else $error("numerator changed silently");
  property p_sync;
    o_align.sync |-> $past(wsync) || $past(wsync, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync without command");
  property p_pair;
    !b20;
  endproperty
  a_pair: assert property (p_pair) else $error("pair sources differ");
  property p_ref;
    o_route.src[0] == PDS_S_REF || o_route.src[1] == PDS_S_REF |-> o_route.ref_pick inside {1, 2};
  endproperty
  a_ref: assert property (p_ref) else $error("reference without pick");
endmodule : pds_ctrl_asserts

bind pds_ctrl pds_ctrl_asserts u_chk (.i_clk, .i_reset_n, .i_apb, .o_apb, .i_xo_ok,
  .i_cal_done, .i_lock, .i_ref_clk, .i_fb_clk, .o_cal_start, .o_route, .o_align,
  .o_steer_num, .o_steer_vld);

// ===== pds_ctrl_bench.sv
// Purpose: Self-checking bench for pds_ctrl.
// Assumes: Zero-wait APB slave; loops report done and lock on demand.
// Notes: Expected values follow the register field ranges.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pds_ctrl_bench;
  import pds_pkg::*;
  logic i_clk;
  logic i_reset_n;
  pds_apb_req_t i_apb;
  pds_apb_rsp_t o_apb;
  logic i_xo_ok;
  logic [2:0] i_cal_done;
  logic [2:0] i_lock;
  logic [1:0] i_ref_clk = 2'h0;
  logic i_fb_clk = 1'b0;
  logic [2:0] o_cal_start;
  pds_route_t o_route;
  pds_align_t o_align;
  logic [39:0] o_steer_num;
  logic o_steer_vld;
  int errors = 0;
  int samples_checked = 0;
  logic [33:0] notes[$];
  logic [33:0] n;
  int gaps[$];
  int cyc = 0;
  int lastv = 0;
  logic [2:0] cs_seen = 3'h0;
  logic cs_clr = 1'b0;
  logic sync_seen = 1'b0;
  logic [4:0] rexp;
  int gb = 0;
  logic [39:0] steers[$];
  logic [3:0] ck = 4'h0;
  logic [31:0] rnd = 32'hf857;
  pds_ctrl dut (.i_clk, .i_reset_n, .i_apb, .o_apb, .i_xo_ok, .i_cal_done, .i_lock,
    .i_ref_clk, .i_fb_clk, .o_cal_start, .o_route, .o_align, .o_steer_num, .o_steer_vld);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [4:0] clampv(input logic [3:0] v, input logic [3:0] lo,
                                        input logic [3:0] hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clampv
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] note);
    int k;
    k = 0;
    @(posedge i_clk);
    i_apb <= '{1'b1, 1'b0, w, a, d};
    notes.push_back(note);
    @(posedge i_clk);
    i_apb.penable <= 1'b1;
    @(posedge i_clk);
    while (!o_apb.pready && k < 50)
    begin
      @(posedge i_clk);
      k++;
    end
    i_apb <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 34'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {2'b10, e});
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle
  task automatic stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Clock, link stimulus and monitor
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    ck <= ck + 4'h1;
    i_fb_clk <= ck[1];
    i_ref_clk <= {ck[2], ck[0]};
  end
  always @(negedge i_clk)
  begin
    cyc++;
    cs_seen = (cs_clr ? 3'h0 : cs_seen) | o_cal_start;
    sync_seen |= o_align.sync;
    if (o_steer_vld)
    begin
      gaps.push_back(cyc - lastv);
      steers.push_back(o_steer_num);
      lastv = cyc;
    end
    if (i_apb.psel && i_apb.penable && o_apb.pready)
    begin
      n = notes.pop_front();
      if (n[33])
        `CHK({o_apb.pslverr, o_apb.prdata}, n[32:0])
      else
        `CHK(o_apb.pslverr, n[32])
    end
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors++;
    stop_test;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    i_reset_n = 1'b0;
    i_apb = '0;
    i_xo_ok = 1'b0;
    i_cal_done = 3'h0;
    i_lock = 3'h0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(PDS_A_CTRL, 32'h7);
    rd(PDS_A_MUTE, 32'hffff);
    rd(PDS_A_PDIV, 32'h22201);
    xfer(1'b0, 8'h4c, 32'h0, {2'b11, 32'h0});
    xfer(1'b1, 8'h4c, 32'h1, {2'b01, 32'h0});
    wr(PDS_A_MUTE, 32'hfffe);
    settle;
    `CHK(cs_seen, 3'h0)
    `CHK(o_route.mute, 16'hfffe)
    @(posedge i_clk);
    i_xo_ok <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_cal_done <= 3'h7;
    settle;
    `CHK(cs_seen, 3'h7)
    `CHK(o_route.mute, 16'hfffe)
    @(posedge i_clk);
    i_lock <= 3'h7;
    settle;
    `CHK(o_route.mute, 16'h0)
    rd(PDS_A_STAT, 32'h107);
    cs_clr = 1'b1;
    @(negedge i_clk);
    cs_clr <= 1'b0;
    wr(PDS_A_CTRL, 32'h5);
    wr(PDS_A_CTRL, 32'h7);
    settle;
    `CHK(cs_seen, 3'h2)
    wr(PDS_A_CTRL, 32'h5107);
    wr(PDS_A_ZD, 32'h1234);
    settle;
    `CHK(sync_seen, 1'b1)
    `CHK(o_align.en, 3'h5)
    `CHK(o_align.offset, 16'h1234)
    repeat (24)
    begin
      rnd = lfsr(rnd);
      wr(PDS_A_PDIV, rnd);
      settle;
      rexp = clampv(rnd[3:0], 4'h1, 4'h8);
      `CHK(o_route.res_div, (rnd[4] && rexp >= 5) ? rexp * 2 : rexp)
      `CHK(o_route.l2_div, clampv(rnd[11:8], 4'h2, 4'hd))
      `CHK(o_route.l1p_div, clampv({1'b0, rnd[14:12]}, 4'h2, 4'h7))
      `CHK(o_route.l1s_div, clampv({1'b0, rnd[18:16]}, 4'h2, 4'h7))
    end
    wr(PDS_A_PDIV, 32'h22201);
    for (int c = 0; c < 4; c++)
    begin
      wr(PDS_A_SRCB, 32'h1500 | (c * 32'h55));
      settle;
      `CHK(o_route.src[2], (c == 3) ? PDS_S_NONE : 3'(c))
      `CHK(o_route.src[15], (c == 3) ? PDS_S_NONE : 3'(c))
      `CHK(o_route.src[5], PDS_S_L2)
      `CHK(o_route.src[7], PDS_S_RES)
      `CHK(o_route.src[13], PDS_S_L2)
    end
    wr(PDS_A_PDIV, 32'h22203);
    wr(PDS_A_SRCB, 32'h10);
    settle;
    `CHK(o_route.src[15], PDS_S_NONE)
    `CHK(o_route.src[14], PDS_S_L2)
    `CHK(o_route.src[2], PDS_S_RES)
    wr(PDS_A_PDIV, 32'h22201);
    settle;
    `CHK(o_route.src[15], PDS_S_RES)
    for (int c = 0; c < 7; c++)
    begin
      wr(PDS_A_SRC01, c | ((c % 5) << 4));
      settle;
      `CHK(o_route.src[0], (c > 4) ? PDS_S_NONE : 3'(c))
      `CHK(o_route.src[1], 3'(c % 5))
    end
    for (int s = 0; s < 3; s++)
    begin
      wr(PDS_A_SRC01, 32'h155 | (s << 16));
      settle;
      `CHK(o_route.src[1], (s == 0) ? PDS_S_NONE : PDS_S_REF)
      `CHK(o_route.ref_pick, 2'(s))
    end
    wr(PDS_A_RDIV0, 32'h0);
    rd(PDS_A_RDIV0, 32'h1);
    wr(PDS_A_RDIV1, 32'h1ffff);
    rd(PDS_A_RDIV1, 32'hffff);
    wr(PDS_A_INT_L, 32'h2);
    repeat (40) @(posedge i_clk);
    gb = gaps.size();
    repeat (40) @(posedge i_clk);
    `CHK(gaps[gb + 1], 8)
    wr(PDS_A_PRE_L, 32'h2);
    repeat (40) @(posedge i_clk);
    gb = gaps.size();
    repeat (60) @(posedge i_clk);
    `CHK(gaps[gb + 1], 16)
    wr(PDS_A_PRE_L, 32'h1);
    wr(PDS_A_DEN_L, 32'h2);
    wr(PDS_A_NUM_L, 32'h1);
    repeat (60) @(posedge i_clk);
    gb = gaps.size();
    repeat (80) @(posedge i_clk);
    `CHK(gaps[gb + 1] + gaps[gb + 2], 20)
    `CHK(steers[$] - steers[$ - 1], 40'h1)
    stop_test;
  end
endmodule : pds_ctrl_bench
